// ==== common/cbx_map.vh ====
// Purpose: constants for the conditional branch execution unit
// Assumes: operation codes are chosen by the enclosing core decoder
// Notes:   state counts are not-taken figures; taken adds CBX_TAKEN_ADD
`ifndef CBX_MAP_VH
`define CBX_MAP_VH

// Operation select codes
`define CBX_OP_CARRY      4'h0
`define CBX_OP_NO_CARRY   4'h1
`define CBX_OP_EQ         4'h2
`define CBX_OP_NE         4'h3
`define CBX_OP_GTU        4'h4
`define CBX_OP_LEU        4'h5
`define CBX_OP_LTS        4'h6
`define CBX_OP_LES        4'h7
`define CBX_OP_GTS        4'h8
`define CBX_OP_GES        4'h9
`define CBX_OP_BIT_SET    4'ha
`define CBX_OP_BIT_CLR    4'hb
`define CBX_OP_BIT_TCLR   4'hc
`define CBX_OP_ACC_ZERO   4'hd
`define CBX_OP_ACC_NZ     4'he
`define CBX_OP_CMP        4'hf
`define CBX_OP_DEC        4'h0

// Operand form codes
`define CBX_FORM_SHORT    3'h0
`define CBX_FORM_EXT      3'h1
`define CBX_FORM_IMM_REG  3'h2
`define CBX_FORM_IMM_IND  3'h3
`define CBX_FORM_DIRECT   3'h4
`define CBX_FORM_REG      3'h5

// Operand space codes
`define CBX_SPACE_MEM     2'h0
`define CBX_SPACE_PORT    2'h1
`define CBX_SPACE_SFR     2'h2

// Timing
`define CBX_TAKEN_ADD     4'h3
`define CBX_ODD_ADD       4'h1
`define CBX_PORT_ADD      4'h1
`define CBX_SFR_ADD       4'h2
`define CBX_DEC_PORT_ADD  4'h2
`define CBX_DEC_SFR_ADD   4'h3
`define CBX_TCLR_PORT_ADD 4'h3
`define CBX_TCLR_SFR_ADD  4'h5

`endif

// ==== design/cbx_branch_exec.v ====
// Purpose: conditional branch execution for an extended 8-bit core
// Assumes: decoder supplies operation, form, operands in one start cycle
// Notes:   decrement is selected by dec_sel, which overrides op
`timescale 1ns/1ns
`include "cbx_map.vh"

module cbx_branch_exec #(
	parameter PC_W = 24
) (
	// Clock and reset
	input  wire            clk,
	input  wire            srst,
	// Request from decoder
	input  wire            start,
	input  wire [3:0]      op,
	input  wire            dec_sel,
	input  wire [2:0]      form,
	input  wire [1:0]      space,
	input  wire            source_mode,
	input  wire            internal_exec,
	input  wire [PC_W-1:0] pc,
	input  wire [7:0]      rel,
	// Status and operands
	input  wire            zero_flag,
	input  wire            carry_flag,
	input  wire            neg_flag,
	input  wire            ovf_flag,
	input  wire [7:0]      working_register_a,
	input  wire [7:0]      opnd1,
	input  wire [7:0]      opnd2,
	input  wire [7:0]      bit_sel,
	// Results
	output reg  [PC_W-1:0] next_pc,
	output reg             taken,
	output reg  [3:0]      inst_len,
	output reg  [3:0]      states,
	output reg             done,
	output reg             carry_we,
	output reg             carry_out,
	output reg             opnd_we,
	output reg  [7:0]      opnd_out
);

	////////////////////////////////////////////////////////////////////
	reg             cond;
	reg [3:0]       len_c;
	reg [3:0]       base_c;
	reg [3:0]       extra_c;
	reg [7:0]       dec_val;
	reg             bitv;
	reg [PC_W-1:0]  seq_pc;
	reg [PC_W-1:0]  dest_pc;
	reg [3:0]       st_c;

	always @* begin
		bitv    = |(opnd1 & bit_sel);
		dec_val = opnd1 - 8'h01;
		cond    = 1'b0;
		len_c   = 4'h2;
		base_c  = 4'h1;
		extra_c = 4'h0;
		if (dec_sel) begin
			cond = |dec_val;
			if (form == `CBX_FORM_DIRECT) begin
				len_c  = 4'h3;
				base_c = 4'h3;
				if (space == `CBX_SPACE_PORT)
					extra_c = `CBX_DEC_PORT_ADD;
				else if (space == `CBX_SPACE_SFR)
					extra_c = `CBX_DEC_SFR_ADD;
			end else begin
				len_c  = source_mode ? 4'h3 : 4'h2;
				base_c = source_mode ? 4'h3 : 4'h2;
			end
		end else begin
			case (op)
			`CBX_OP_CARRY:    cond = carry_flag;
			`CBX_OP_NO_CARRY: cond = ~carry_flag;
			`CBX_OP_EQ:       cond = zero_flag;
			`CBX_OP_NE:       cond = ~zero_flag;
			`CBX_OP_GTU:      cond = ~carry_flag & ~zero_flag;
			`CBX_OP_LEU:      cond = carry_flag | zero_flag;
			`CBX_OP_LTS:      cond = neg_flag ^ ovf_flag;
			`CBX_OP_LES:      cond = (neg_flag ^ ovf_flag) | zero_flag;
			`CBX_OP_GTS:      cond = ~(neg_flag ^ ovf_flag) & ~zero_flag;
			`CBX_OP_GES:      cond = ~(neg_flag ^ ovf_flag);
			`CBX_OP_BIT_SET:  cond = bitv;
			`CBX_OP_BIT_CLR:  cond = ~bitv;
			`CBX_OP_BIT_TCLR: cond = bitv;
			`CBX_OP_ACC_ZERO: cond = (working_register_a == 8'h00);
			`CBX_OP_ACC_NZ:   cond = (working_register_a != 8'h00);
			`CBX_OP_CMP:      cond = (opnd1 != opnd2);
			default:          cond = 1'b0;
			endcase
			case (op)
			`CBX_OP_CARRY, `CBX_OP_NO_CARRY: begin
				len_c  = 4'h2;
				base_c = 4'h1;
			end
			`CBX_OP_ACC_ZERO, `CBX_OP_ACC_NZ: begin
				len_c  = 4'h2;
				base_c = 4'h2;
			end
			`CBX_OP_BIT_SET, `CBX_OP_BIT_CLR, `CBX_OP_BIT_TCLR: begin
				if (form == `CBX_FORM_EXT) begin
					len_c  = source_mode ? 4'h4 : 4'h5;
					base_c = source_mode ? 4'h3 : 4'h4;
				end else begin
					len_c  = 4'h3;
					base_c = 4'h2;
				end
				if (op == `CBX_OP_BIT_TCLR) begin
					// Legacy form 4/7, extended form bit base plus 3
					base_c = (form == `CBX_FORM_EXT) ?
						base_c + 4'h3 : 4'h4;
					if (space == `CBX_SPACE_PORT)
						extra_c = `CBX_TCLR_PORT_ADD;
					else if (space == `CBX_SPACE_SFR)
						extra_c = `CBX_TCLR_SFR_ADD;
				end else if (space == `CBX_SPACE_PORT)
					extra_c = `CBX_PORT_ADD;
				else if (space == `CBX_SPACE_SFR)
					extra_c = `CBX_SFR_ADD;
			end
			`CBX_OP_CMP: begin
				len_c  = 4'h3;
				base_c = 4'h2;
				if (form == `CBX_FORM_IMM_REG) begin
					len_c  = source_mode ? 4'h4 : 4'h3;
					base_c = source_mode ? 4'h3 : 4'h2;
				end else if (form == `CBX_FORM_IMM_IND) begin
					len_c  = source_mode ? 4'h4 : 4'h3;
					base_c = source_mode ? 4'h4 : 4'h3;
				end else if (form == `CBX_FORM_DIRECT) begin
					if (space == `CBX_SPACE_PORT)
						extra_c = `CBX_PORT_ADD;
					else if (space == `CBX_SPACE_SFR)
						extra_c = `CBX_SFR_ADD;
				end
			end
			default: begin
				len_c  = source_mode ? 4'h2 : 4'h3;
				base_c = source_mode ? 4'h1 : 4'h2;
			end
			endcase
		end
		seq_pc  = pc + {{(PC_W-4){1'b0}}, len_c};
		dest_pc = seq_pc + {{(PC_W-8){rel[7]}}, rel};
		st_c    = base_c + extra_c;
		if (cond) begin
			st_c = st_c + `CBX_TAKEN_ADD;
			if (internal_exec && dest_pc[0])
				st_c = st_c + `CBX_ODD_ADD;
		end
	end

	////////////////////////////////////////////////////////////////////
	always @(posedge clk) begin
		if (srst) begin
			next_pc   <= {PC_W{1'b0}};
			taken     <= 1'b0;
			inst_len  <= 4'h0;
			states    <= 4'h0;
			done      <= 1'b0;
			carry_we  <= 1'b0;
			carry_out <= 1'b0;
			opnd_we   <= 1'b0;
			opnd_out  <= 8'h00;
		end else begin
			done     <= start;
			carry_we <= 1'b0;
			opnd_we  <= 1'b0;
			if (start) begin
				next_pc  <= cond ? dest_pc : seq_pc;
				taken    <= cond;
				inst_len <= len_c;
				states   <= st_c;
				opnd_out <= opnd1;
				if (dec_sel) begin
					opnd_we  <= 1'b1;
					opnd_out <= dec_val;
				end else if (op == `CBX_OP_CMP) begin
					carry_we  <= 1'b1;
					carry_out <= (opnd1 < opnd2);
				end else if (op == `CBX_OP_BIT_TCLR && bitv) begin
					opnd_we  <= 1'b1;
					opnd_out <= opnd1 & ~bit_sel;
				end
			end
		end
	end

endmodule

// ==== testbench/cbx_exec_checker.sv ====
// Purpose: port checks of the branch unit
// Assumes: one clock, srst synchronous
// Notes:   bound into the design
`timescale 1ns/1ns
`include "cbx_map.vh"
module cbx_exec_checker #(
	parameter PC_W = 24
) (
	input wire clk, srst, start, dec_sel, zero_flag, carry_flag,
	input wire internal_exec, taken, done, carry_we, carry_out, opnd_we,
	input wire [3:0] op, inst_len, states,
	input wire [7:0] rel, working_register_a, opnd1, opnd2, opnd_out,
	input wire [PC_W-1:0] pc, next_pc
);
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	wire [PC_W-1:0] rel_x = {{(PC_W-8){rel[7]}}, rel};
	sequence op_s(logic [3:0] c);
		start && !dec_sel && op == c;
	endsequence
	done_after_a: assert property (start |=> done)
		else $error("done missing");
	pc_sum_a: assert property (start |=> next_pc == $past(pc) + inst_len
		+ (taken ? $past(rel_x) : {PC_W{1'b0}})) else $error("next pc wrong");
	carry_len_a: assert property (op_s(`CBX_OP_CARRY) |=>
		taken == $past(carry_flag) && inst_len == 4'h2) else $error("carry br");
	carry_states_a: assert property (op_s(`CBX_OP_CARRY) ##0 !internal_exec
		|=> states == (taken ? 4'h4 : 4'h1)) else $error("carry states");
	acc_zero_a: assert property (op_s(`CBX_OP_ACC_ZERO) |=>
		taken == ($past(working_register_a) == 8'h00)) else $error("acc zero");
	cmp_carry_a: assert property (op_s(`CBX_OP_CMP) |=> carry_we &&
		carry_out == ($past(opnd1) < $past(opnd2)) &&
		taken == ($past(opnd1) != $past(opnd2))) else $error("compare");
	dec_write_a: assert property (start && dec_sel |=> opnd_we &&
		opnd_out == $past(opnd1) - 8'h01 && taken == (opnd_out != 8'h00))
		else $error("decrement");
	idle_quiet_a: assert property (!start |=> !done && !carry_we && !opnd_we)
		else $error("stray pulse");
	eq_zero_a: assert property (op_s(`CBX_OP_EQ) |=> taken == $past(zero_flag))
		else $error("equal br");
endmodule
bind cbx_branch_exec cbx_exec_checker #(.PC_W(PC_W)) i_chk (.clk, .srst,
	.start, .dec_sel, .zero_flag, .carry_flag, .internal_exec, .taken, .done,
	.carry_we, .carry_out, .opnd_we, .op, .inst_len, .states, .rel,
	.working_register_a, .opnd1, .opnd2, .opnd_out, .pc, .next_pc);

// ==== testbench/cbx_reg_space.sv ====
// Purpose: operand store on the far side of the branch unit
// Assumes: write-back lands one edge after the request
// Notes:   resets to its own index
`timescale 1ns/1ns
module cbx_reg_space (
	input  wire       clk,
	input  wire       srst,
	input  wire       start,
	input  wire [2:0] addr,
	output wire [7:0] rdata,
	input  wire       we,
	input  wire [7:0] wdata
);
	reg [7:0] mem [0:7];
	reg [2:0] wa_reg;
	integer   n;
	assign rdata = mem[addr];
	always @(posedge clk) begin
		if (start)
			wa_reg <= addr;
		if (srst)
			for (n = 0; n < 8; n = n + 1)
				mem[n] <= n[7:0];
		else if (we)
			mem[wa_reg] <= wdata;
	end
endmodule

// ==== testbench/testbench.sv ====
// Purpose: random back-to-back branches against a bench model
// Assumes: operand addresses rotate so write-backs never collide
// Notes:   LFSR stimulus from 32'h63eb
`timescale 1ns/1ns
`include "cbx_map.vh"
module testbench;
	reg clk = 0, srst = 1, start = 0, dec_sel = 0, source_mode = 0;
	reg internal_exec = 0, zero_flag = 0, carry_flag = 0, neg_flag = 0;
	reg ovf_flag = 0, e_go = 0, cw = 0, co = 0, we = 0, t = 0;
	reg [3:0] op = 0, ln = 0, st = 0;
	reg [2:0] form = 0, addr = 0;
	reg [1:0] space = 0;
	reg [23:0] pc = 0, e_pc = 0;
	reg [7:0] rel = 0, working_register_a = 0, opnd2 = 0, bit_sel = 0;
	reg [7:0] oo = 0, c = 0, v = 0, mm [0:7];
	reg [31:0] r = 32'h63eb;
	wire [7:0] opnd1, opnd_out;
	wire [23:0] next_pc;
	wire [3:0] inst_len, states;
	wire taken, done, carry_we, carry_out, opnd_we;
	integer errors = 0, tests_run = 0, cyc = 0, i, k;
	cbx_branch_exec i_cbx_branch_exec (.clk, .srst, .start, .op, .dec_sel,
		.form, .space, .source_mode, .internal_exec, .pc, .rel, .zero_flag,
		.carry_flag, .neg_flag, .ovf_flag, .working_register_a, .opnd1,
		.opnd2, .bit_sel, .next_pc, .taken, .inst_len, .states, .done,
		.carry_we, .carry_out, .opnd_we, .opnd_out);
	cbx_reg_space i_cbx_reg_space (.clk, .srst, .start, .addr, .rdata(opnd1),
		.we(opnd_we), .wdata(opnd_out));
	initial forever #4 clk = ~clk;
	always @(posedge clk) begin
		cyc = cyc + 1;
		if (cyc == 3000) begin
			errors = errors + 1;
			print_verdict;
		end
	end
	task chk(input [8*6-1:0] n, input [39:0] e, input [39:0] s);
		begin
			tests_run = tests_run + 1;
			if (e !== s) begin
				errors = errors + 1;
				$display("unexpected %s: expected %h seen %h", n, e, s);
			end
		end
	endtask
	task print_verdict;
		begin
			if (errors == 0 && tests_run > 0)
				$display("Simulation passed");
			else
				$display("Simulation failed");
			$finish;
		end
	endtask
	function [31:0] lfsr(input [31:0] s);
		lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task issue;
		begin
			r = lfsr(r);
			k = r % 17;
			start = r[7:6] != 2'h0;
			dec_sel = k == 16;
			op = k[3:0];
			form = dec_sel ? `CBX_FORM_REG : k == 15 ? `CBX_FORM_IMM_REG : 3'h0;
			space = (k > 9 && k < 13) ? r[9:8] % 3 : 2'h0;
			{source_mode, internal_exec} = r[11:10];
			{zero_flag, carry_flag, neg_flag, ovf_flag} = r[15:12];
			{pc, rel} = r;
			bit_sel = 8'h01 << r[2:0];
			working_register_a = r[4] ? 8'h00 : r[31:24];
			addr = i[2:0];
			v = mm[addr];
			opnd2 = r[5] ? v : r[23:16];
			c = {~(neg_flag ^ ovf_flag), ~(neg_flag ^ ovf_flag | zero_flag),
				neg_flag ^ ovf_flag | zero_flag, neg_flag ^ ovf_flag,
				carry_flag | zero_flag, ~carry_flag & ~zero_flag, ~zero_flag,
				zero_flag};
			{ln, st} = source_mode ? 8'h21 : 8'h32;
			t = k < 2 ? carry_flag ^ k[0] : c[k-2];
			if (k < 2)
				{ln, st} = 8'h21;
			if (k > 9 && k < 13) begin
				t = |(v & bit_sel) ^ (k == 11);
				{ln, st} = k == 12 ? 8'h34 : 8'h32;
				st = st + (space == 1 ? (k == 12 ? 3 : 1) :
					space == 2 ? (k == 12 ? 5 : 2) : 0);
			end
			if (k == 13 || k == 14) begin
				t = (working_register_a == 0) ^ (k == 14);
				{ln, st} = 8'h22;
			end
			if (k == 15) begin
				t = v != opnd2;
				{ln, st} = source_mode ? 8'h43 : 8'h32;
			end
			oo = k == 16 ? v - 8'h01 : v & ~bit_sel;
			if (k == 16) begin
				t = oo != 0;
				{ln, st} = source_mode ? 8'h33 : 8'h22;
			end
			e_pc = pc + ln + (t ? {{16{rel[7]}}, rel} : 24'h0);
			st = st + (t ? 3 + (internal_exec & e_pc[0]) : 0);
			{cw, co, we} = {k == 15, v < opnd2, k == 16 || (k == 12 && t)};
			if (we && start)
				mm[addr] = oo;
			e_go = start;
		end
	endtask
	initial begin
		for (k = 0; k < 8; k = k + 1)
			mm[k] = k;
		repeat (20) @(posedge clk);
		@(negedge clk);
		srst = 0;
		for (i = 0; i < 600; i = i + 1) begin
			issue;
			@(negedge clk);
			chk("done", e_go, done);
			if (e_go) begin
				chk("result", {e_pc, t, ln, st, cw, we},
					{next_pc, taken, inst_len, states, carry_we, opnd_we});
				if (cw)
					chk("carry", co, carry_out);
				if (we)
					chk("wrback", oo, opnd_out);
			end
		end
		print_verdict;
	end
endmodule
